// File: dv/plp_programmer.sv
/*
  Programmer model: drives mode, address, data and program strobe.
  Assumes a 40 MHz ref_clk and the lock block on the far side.
*/
`default_nettype none
module plp_programmer #(
  parameter int ADDR_W  = 14,
  parameter int LOW_CYC = 3600,
  parameter int GAP_CYC = 400
) (
  input  wire logic               ref_clk,
  input  wire logic [7:0]         pgm_data_out,
  input  wire logic               pgm_data_oe_n,
  output var  plp_pkg::plp_mode_e pgm_mode,
  output var  logic [ADDR_W-1:0]  pgm_addr,
  output var  logic [7:0]         pgm_data_in,
  output var  logic               program_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import plp_pkg::*;
  initial begin
    pgm_mode = PLP_MODE_IDLE;
    pgm_addr = '0;
    pgm_data_in = 8'h00;
    program_strobe_n = 1'b1;
  end
  // ==========================================================
  // programming burst
  // low phase may be shortened: the block acts on each falling edge
  task automatic burst(input plp_mode_e m, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = (m == PLP_MODE_CODE) ? 5 : 25;
    @(posedge ref_clk);
    pgm_mode <= m;
    pgm_addr <= a;
    pgm_data_in <= d;
    repeat (n) begin
      repeat (GAP_CYC) @(posedge ref_clk);
      program_strobe_n <= 1'b0;
      repeat (LOW_CYC) @(posedge ref_clk);
      program_strobe_n <= 1'b1;
    end
    repeat (GAP_CYC) @(posedge ref_clk);
    pgm_mode <= PLP_MODE_IDLE;
    // released data lines must not keep the old byte
    pgm_data_in <= ~d;
  endtask : burst
  // ==========================================================
  // two one-cycle pulses in idle mode with a short high gap between them
  task automatic pulse_pair(input int gap);
    repeat (2) begin
      @(posedge ref_clk);
      program_strobe_n <= 1'b0;
      @(posedge ref_clk);
      program_strobe_n <= 1'b1;
      repeat (gap) @(posedge ref_clk);
    end
  endtask : pulse_pair
  // ==========================================================
  // verify read
  task automatic verify(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic oe_n);
    @(posedge ref_clk);
    pgm_mode <= PLP_MODE_VERIFY;
    pgm_addr <= a;
    @(posedge ref_clk);
    #1;
    d = pgm_data_out;
    oe_n = pgm_data_oe_n;
    @(posedge ref_clk);
    pgm_mode <= PLP_MODE_IDLE;
  endtask : verify
endmodule : plp_programmer
`default_nettype wire

// File: dv/program_lock_protection_tb_top.sv
/*
  Testbench: erase, programming at the open level, each lock level, erase.
  Assumes plp_pkg, plp_params.svh and the programmer model.
*/
`default_nettype none
`include "plp_params.svh"
module program_lock_protection_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import plp_pkg::*;
  localparam int AW = 7;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic clk_en = 1'b1;
  plp_mode_e pgm_mode;
  logic [AW-1:0] pgm_addr;
  logic [AW-1:0] table_read_addr = 7'h05;
  logic [7:0] pgm_data_in, pgm_data_out, table_read_data;
  logic pgm_data_oe_n, program_strobe_n, ext_access_eff_n;
  logic external_access_select_n = 1'b1;
  logic code_table_read_instruction = 1'b0;
  logic table_read_from_ext = 1'b0;
  logic ext_fetch_req = 1'b0;
  logic table_read_blocked, ext_fetch_blocked;
  int err_total = 0;
  int n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  plp_lock_ctrl #(.ADDR_W(AW), .ENC_W(6)) plp_lock_ctrl_i (
    .ref_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pgm_mode, .pgm_addr, .pgm_data_in, .pgm_data_out, .pgm_data_oe_n,
    .program_strobe_n, .external_access_select_n, .ext_access_eff_n,
    .code_table_read_instruction, .table_read_from_ext, .table_read_addr, .table_read_data,
    .table_read_blocked, .ext_fetch_req, .ext_fetch_blocked);
  plp_programmer #(.ADDR_W(AW), .LOW_CYC(4)) plp_programmer_i (
    .ref_clk, .pgm_data_out, .pgm_data_oe_n, .pgm_mode, .pgm_addr, .pgm_data_in,
    .program_strobe_n);
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic level_is(input logic [2:0] lk, input plp_level_e lv);
    logic [31:0] st;
    reg_read(`PLP_OFS_STATUS, st);
    check("lock bits", 32'(st[`PLP_ST_LOCK_MSB:`PLP_ST_LOCK_LSB]), 32'(lk));
    check("level", 32'(st[`PLP_ST_LVL_MSB:`PLP_ST_LVL_LSB]), 32'(lv));
  endtask : level_is
  task automatic erase_all;
    logic [31:0] st;
    reg_write(`PLP_OFS_CTRL, 32'h1 << `PLP_CTRL_ERASE);
    st = 32'h1 << `PLP_ST_BUSY;
    for (int i = 0; i < 200 && st[`PLP_ST_BUSY] !== 1'b0; i++) reg_read(`PLP_OFS_STATUS, st);
    check("erase busy", 32'(st[`PLP_ST_BUSY]), 32'h0);
  endtask : erase_all
  task automatic vfy(input logic [AW-1:0] a, input logic [7:0] ed, input logic eoe);
    logic [7:0] d;
    logic oe;
    plp_programmer_i.verify(a, d, oe);
    check("verify byte", 32'(d), 32'(ed));
    check("verify oe_n", 32'(oe), 32'(eoe));
  endtask : vfy
  task automatic probe(input logic ext, input logic [7:0] ed, input logic eb, input logic ef);
    @(posedge ref_clk);
    code_table_read_instruction <= 1'b1;
    table_read_from_ext <= ext;
    ext_fetch_req <= 1'b1;
    @(posedge ref_clk);
    code_table_read_instruction <= 1'b0;
    ext_fetch_req <= 1'b0;
    #1;
    check("table data", 32'(table_read_data), 32'(ed));
    check("table blocked", 32'(table_read_blocked), 32'(eb));
    check("fetch blocked", 32'(ext_fetch_blocked), 32'(ef));
  endtask : probe
  task automatic pin_is(input logic pin, input logic ee);
    @(posedge ref_clk);
    external_access_select_n <= pin;
    repeat (2) @(posedge ref_clk);
    #1 check("access effective", 32'(ext_access_eff_n), 32'(ee));
  endtask : pin_is
  // ==========================================================
  // scenarios
  task automatic t_open;
    logic [31:0] d;
    erase_all();
    level_is(3'h0, PLP_LVL_OPEN);
    reg_read(8'h08, d);
    check("unmapped read", d, 32'h0);
    vfy(7'h05, `PLP_ERASED_BYTE, 1'b0);
    plp_programmer_i.burst(PLP_MODE_CODE, 7'h05, 8'h3c);
    vfy(7'h05, 8'h3c, 1'b0);
    plp_programmer_i.burst(PLP_MODE_ENC, 7'h05, 8'h0f);
    vfy(7'h05, 8'hcc, 1'b0);
    vfy(7'h45, 8'h0f, 1'b0);
    probe(1'b1, 8'h3c, 1'b0, 1'b0);
    pin_is(1'b0, 1'b0);
    pin_is(1'b1, 1'b1);
    $display("test open level done");
  endtask : t_open
  task automatic t_level2;
    plp_programmer_i.burst(PLP_MODE_LOCK1, 7'h00, 8'h00);
    level_is(3'h1, PLP_LVL_TBL);
    probe(1'b1, 8'h00, 1'b1, 1'b0);
    probe(1'b0, 8'h3c, 1'b0, 1'b0);
    plp_programmer_i.burst(PLP_MODE_CODE, 7'h06, 8'h00);
    vfy(7'h06, 8'hff, 1'b0);
    @(posedge ref_clk);
    reset <= 1'b1;
    external_access_select_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    pin_is(1'b1, 1'b0);
    $display("test level two done");
  endtask : t_level2
  task automatic t_level34;
    plp_programmer_i.burst(PLP_MODE_LOCK2, 7'h00, 8'h00);
    level_is(3'h3, PLP_LVL_NOVFY);
    vfy(7'h05, 8'h00, 1'b1);
    probe(1'b1, 8'h00, 1'b1, 1'b0);
    plp_programmer_i.burst(PLP_MODE_LOCK3, 7'h00, 8'h00);
    level_is(3'h7, PLP_LVL_NOEXT);
    probe(1'b1, 8'h00, 1'b1, 1'b1);
    pin_is(1'b1, 1'b0);
    $display("test levels three and four done");
  endtask : t_level34
  task automatic t_erase_back;
    erase_all();
    level_is(3'h0, PLP_LVL_OPEN);
    vfy(7'h05, 8'hff, 1'b0);
    probe(1'b1, 8'hff, 1'b0, 1'b0);
    $display("test erase back done");
  endtask : t_erase_back
  task automatic t_gap_freeze;
    logic [31:0] d;
    plp_programmer_i.pulse_pair(8);
    reg_read(`PLP_OFS_STATUS, d);
    check("gap error", 32'(d[`PLP_ST_GAP_ERR]), 32'h1);
    reg_write(`PLP_OFS_CTRL, 32'h1 << `PLP_CTRL_CLR_GAP);
    reg_read(`PLP_OFS_STATUS, d);
    check("gap cleared", 32'(d[`PLP_ST_GAP_ERR]), 32'h0);
    // with the enable low the read strobe must not reach the read data
    @(posedge ref_clk);
    clk_en <= 1'b0;
    reg_read(`PLP_OFS_STATUS, d);
    check("frozen read", d, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    $display("test gap and freeze done");
  endtask : t_gap_freeze
  // ==========================================================
  // sequence and watchdog
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_open();
    t_level2();
    t_level34();
    t_erase_back();
    t_gap_freeze();
    end_sim();
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    err_total++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : program_lock_protection_tb_top
`default_nettype wire

// File: src/plp_lock_ctrl.sv
/*
  Program lock protection: code store, encryption table, three lock bits,
  programming/verify port, cpu-side gating of table reads, external fetch
  and the external-access select pin.
  Assumes all inputs synchronous to ref_clk and a programmer that keeps
  its own pulse counts and strobe spacing.
*/
// Summary of operation
// (R01) with no lock bits set nothing is locked; verify output stays encrypted
// (R02) level two blocks table reads from external code into internal store
// (R03) level two and up latch external-access select at reset, ignore pin
// (R04) level two and up ignore program pulses to the code store
// (R05) level three adds verify read-out disabled
// (R06) level four adds external instruction fetch forbidden
// (R07) undefined lock patterns carry no guarantee; treated as fullest lock
// (R08) erased cells read as ones, so erased bytes verify as all ones where the table byte is erased too
// (R09) programmer keeps strobe high at least 10 us between pulses
// (R10) erase clears encryption table and lock bits along with code store
// (R11) programmer gives 5 pulses per code byte, 25 per table or lock bit
// (R12) verify xnors code byte with table byte picked by six low address bits
// (R13) lock bits decode combinationally into a level gating every path except lock-bit programming and erase
`default_nettype none
`include "plp_params.svh"

module plp_lock_ctrl #(
  parameter int ADDR_W = 14,
  parameter int ENC_W  = 6
) (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire plp_pkg::plp_mode_e  pgm_mode,
  input  wire logic [ADDR_W-1:0]   pgm_addr,
  input  wire logic [7:0]          pgm_data_in,
  output logic      [7:0]          pgm_data_out,
  output logic                     pgm_data_oe_n,
  input  wire logic                program_strobe_n,
  input  wire logic                external_access_select_n,
  output logic                     ext_access_eff_n,
  input  wire logic                code_table_read_instruction,
  input  wire logic                table_read_from_ext,
  input  wire logic [ADDR_W-1:0]   table_read_addr,
  output logic      [7:0]          table_read_data,
  output logic                     table_read_blocked,
  input  wire logic                ext_fetch_req,
  output logic                     ext_fetch_blocked
);
  import plp_pkg::*;

  // ========================================================================
  // storage: nonvolatile, so no reset; erase before first use
  logic [7:0]        code_mem [2**ADDR_W];
  logic [7:0]        enc_mem  [2**ENC_W];
  logic [2:0]        lock_reg;

  plp_state_e        state_reg;
  logic [ADDR_W-1:0] sweep_reg;
  logic              strobe_prev_reg;
  logic [`PLP_GAP_CNT_W-1:0] gap_cnt_reg;
  logic              gap_err_reg;
  logic              access_caught_reg;
  logic              first_cycle_reg;

  // ========================================================================
  // level decode
  function automatic plp_level_e plp_decode(input logic [2:0] lb);
    case (lb)
      3'h0:    plp_decode = PLP_LVL_OPEN;
      3'h1:    plp_decode = PLP_LVL_TBL;
      3'h3:    plp_decode = PLP_LVL_NOVFY;
      3'h7:    plp_decode = PLP_LVL_NOEXT;
      // odd patterns get the strongest lock rather than none
      default: plp_decode = PLP_LVL_NOEXT;                          // [R07]
    endcase
  endfunction : plp_decode

  plp_level_e level;
  wire  lvl_ge2 = (level != PLP_LVL_OPEN);                           // [R13]
  wire  lvl_ge3 = (level == PLP_LVL_NOVFY) || (level == PLP_LVL_NOEXT);
  wire  lvl_ge4 = (level == PLP_LVL_NOEXT);
  assign level = plp_decode(lock_reg);                               // [R13]

  // ========================================================================
  // decode of ports
  wire        busy        = (state_reg == PLP_ST_ERASE);
  wire        strobe_fall = strobe_prev_reg && !program_strobe_n;
  wire        pulse       = strobe_fall && !busy;
  wire        wr_ctrl     = reg_wr && (reg_addr == `PLP_OFS_CTRL);
  wire        erase_go    = wr_ctrl && reg_wdata[`PLP_CTRL_ERASE] && !busy;
  wire        gap_clr     = wr_ctrl && reg_wdata[`PLP_CTRL_CLR_GAP];
  wire        gap_short   = strobe_fall && (gap_cnt_reg < `PLP_GAP_CNT_W'(`PLP_STROBE_GAP_CYC));
  wire        code_wr     = pulse && (pgm_mode == PLP_MODE_CODE) && !lvl_ge2;    // [R04]
  wire        enc_wr      = pulse && (pgm_mode == PLP_MODE_ENC) && !lvl_ge2;
  wire [ENC_W-1:0] enc_idx = pgm_addr[ENC_W-1:0];
  wire [7:0]  code_rd     = code_mem[pgm_addr];
  wire [7:0]  vfy_byte    = ~(code_rd ^ enc_mem[enc_idx]);            // [R12] [R01]
  wire        vfy_on      = (pgm_mode == PLP_MODE_VERIFY) && !lvl_ge3;           // [R05]
  wire        tbl_block   = table_read_from_ext && lvl_ge2;           // [R02]
  wire [31:0] status_word = {23'h000000, busy, gap_err_reg, level, lock_reg};
  wire [31:0] rd_mux      = (reg_addr == `PLP_OFS_STATUS) ? status_word : 32'h00000000;

  // ========================================================================
  // erase sweep and lock bits
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= PLP_ST_IDLE;
      sweep_reg <= '0;
    end else if (clk_en) begin
      case (state_reg)
        PLP_ST_IDLE: begin
          sweep_reg <= '0;
          if (erase_go) begin
            state_reg <= PLP_ST_ERASE;
          end
        end
        PLP_ST_ERASE: begin
          sweep_reg <= sweep_reg + 1'b1;
          if (&sweep_reg) begin
            state_reg <= PLP_ST_IDLE;
          end
        end
        default: state_reg <= PLP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (erase_go) begin
        lock_reg <= `PLP_LOCK_NONE;                                  // [R10]
      end else if (pulse) begin
        // lock bits stay programmable at every level
        if (pgm_mode == PLP_MODE_LOCK1) lock_reg[0] <= 1'b1;
        if (pgm_mode == PLP_MODE_LOCK2) lock_reg[1] <= 1'b1;
        if (pgm_mode == PLP_MODE_LOCK3) lock_reg[2] <= 1'b1;
      end
    end
  end

  // programming only pulls bits to zero, as a real cell does
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (busy) begin
        code_mem[sweep_reg] <= `PLP_ERASED_BYTE;                     // [R08]
        enc_mem[sweep_reg[ENC_W-1:0]] <= `PLP_ERASED_BYTE;           // [R10]
      end else begin
        if (code_wr) code_mem[pgm_addr] <= code_rd & pgm_data_in;    // [R04]
        if (enc_wr) enc_mem[enc_idx] <= enc_mem[enc_idx] & pgm_data_in;
      end
    end
  end

  // ========================================================================
  // strobe spacing watch; the programmer owns it, this only reports
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strobe_prev_reg <= 1'b1;
      gap_cnt_reg     <= '1;
      gap_err_reg     <= 1'b0;
    end else if (clk_en) begin
      strobe_prev_reg <= program_strobe_n;
      if (!program_strobe_n) begin
        gap_cnt_reg <= '0;
      end else if (!(&gap_cnt_reg)) begin
        gap_cnt_reg <= gap_cnt_reg + 1'b1;
      end
      if (gap_short) begin
        gap_err_reg <= 1'b1;                                         // [R09]
      end else if (gap_clr) begin
        gap_err_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // external-access latch: pin caught on the first enabled edge after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_cycle_reg   <= 1'b1;
      access_caught_reg <= 1'b1;
    end else if (clk_en) begin
      first_cycle_reg <= 1'b0;
      if (first_cycle_reg) access_caught_reg <= external_access_select_n; // [R03]
    end
  end

  // ========================================================================
  // registered outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata          <= 32'h00000000;
      pgm_data_out       <= 8'h00;
      pgm_data_oe_n      <= 1'b1;
      ext_access_eff_n   <= 1'b1;
      table_read_data    <= 8'h00;
      table_read_blocked <= 1'b0;
      ext_fetch_blocked  <= 1'b0;
    end else if (clk_en) begin
      reg_rdata          <= reg_rd ? rd_mux : 32'h00000000;
      pgm_data_out       <= vfy_on ? vfy_byte : 8'h00;
      pgm_data_oe_n      <= !vfy_on;                                 // [R05]
      ext_access_eff_n   <= first_cycle_reg ? external_access_select_n :
                            (lvl_ge2 ? access_caught_reg : external_access_select_n); // [R03]
      table_read_blocked <= code_table_read_instruction && tbl_block;                // [R02]
      table_read_data    <= (code_table_read_instruction && !tbl_block) ?
                            code_mem[table_read_addr] : 8'h00;
      ext_fetch_blocked  <= ext_fetch_req && lvl_ge4;                // [R06]
    end
  end

  // ========================================================================
  // checks
  chk_lock_decode_open: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (lock_reg == 3'h0) |-> (level == PLP_LVL_OPEN))
    else $error("open lock bits did not decode to level one");

  chk_access_pin_held: assert property (@(posedge ref_clk) disable iff (reset) // [R03]
    (clk_en && lvl_ge2 && !first_cycle_reg) |=> (ext_access_eff_n == access_caught_reg))
    else $error("external access followed the pin while locked");

  chk_code_write_blocked: assert property (@(posedge ref_clk) disable iff (reset) // [R04]
    (clk_en && strobe_fall && !busy && pgm_mode == PLP_MODE_CODE && lvl_ge2)
      |=> (code_mem[$past(pgm_addr)] == $past(code_rd)))
    else $error("code byte changed under programming lock");

  chk_verify_disabled: assert property (@(posedge ref_clk) disable iff (reset) // [R05]
    (clk_en && pgm_mode == PLP_MODE_VERIFY && lvl_ge3) |=> pgm_data_oe_n)
    else $error("verify read-out driven at level three");

  chk_ext_fetch_lock: assert property (@(posedge ref_clk) disable iff (reset) // [R06]
    (clk_en && ext_fetch_req) |=> (ext_fetch_blocked == $past(lvl_ge4)))
    else $error("external fetch gating wrong");

  chk_table_read_gate: assert property (@(posedge ref_clk) disable iff (reset) // [R02]
    (clk_en && code_table_read_instruction && table_read_from_ext && lvl_ge2)
      |=> (table_read_blocked && table_read_data == 8'h00))
    else $error("external table read reached internal store");

  chk_verify_xnor: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
    (clk_en && pgm_mode == PLP_MODE_VERIFY && !lvl_ge3)
      |=> (!pgm_data_oe_n && pgm_data_out == ~($past(code_rd) ^ $past(enc_mem[enc_idx]))))
    else $error("verify byte is not code xnor table");

  chk_erase_unlocks: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
    (clk_en && erase_go) |=> (lock_reg == 3'h0 && busy))
    else $error("erase left lock bits set");

  chk_erase_ones: assert property (@(posedge ref_clk) disable iff (reset) // [R08]
    (clk_en && busy) |=> (code_mem[$past(sweep_reg)] == 8'hff))
    else $error("erased byte not all ones");

endmodule : plp_lock_ctrl

`default_nettype wire

// File: src/plp_params.svh
/*
  Constants for the program lock protection block: register offsets,
  field positions, erase values and timing counts.
  Assumes a 40 MHz ref_clk and a byte-wide programming port.
*/
`ifndef PLP_PARAMS_SVH
`define PLP_PARAMS_SVH

// ==========================================================================
// register map (word offsets on the plain register port)
`define PLP_OFS_STATUS      8'h00
`define PLP_OFS_CTRL        8'h04

// ==========================================================================
// control register fields (write only, self clearing)
`define PLP_CTRL_ERASE      0
`define PLP_CTRL_CLR_GAP    1

// ==========================================================================
// status register fields
`define PLP_ST_LOCK_LSB     0
`define PLP_ST_LOCK_MSB     2
`define PLP_ST_LVL_LSB      3
`define PLP_ST_LVL_MSB      6
`define PLP_ST_GAP_ERR      7
`define PLP_ST_BUSY         8

// ==========================================================================
// values and timing
`define PLP_ERASED_BYTE     8'hff
`define PLP_LOCK_NONE       3'h0
`define PLP_CLK_MHZ         40
`define PLP_STROBE_GAP_US   10
`define PLP_STROBE_GAP_CYC  ((`PLP_STROBE_GAP_US) * (`PLP_CLK_MHZ))
`define PLP_GAP_CNT_W       9

`endif

// File: src/plp_pkg.sv
/*
  Types for the program lock protection block.
  Assumes nothing beyond plp_params.svh for the numeric constants.
*/
`default_nettype none

package plp_pkg;

  // programming port operation, as set up on the control pins
  typedef enum logic [2:0] {
    PLP_MODE_IDLE   = 3'h0,
    PLP_MODE_CODE   = 3'h1,
    PLP_MODE_VERIFY = 3'h2,
    PLP_MODE_ENC    = 3'h3,
    PLP_MODE_LOCK1  = 3'h4,
    PLP_MODE_LOCK2  = 3'h5,
    PLP_MODE_LOCK3  = 3'h6
  } plp_mode_e;

  typedef enum logic [3:0] {
    PLP_LVL_OPEN  = 4'h1,
    PLP_LVL_TBL   = 4'h2,
    PLP_LVL_NOVFY = 4'h4,
    PLP_LVL_NOEXT = 4'h8
  } plp_level_e;

  typedef enum logic [1:0] {
    PLP_ST_IDLE  = 2'h1,
    PLP_ST_ERASE = 2'h2
  } plp_state_e;

endpackage : plp_pkg

`default_nettype wire
